/* File: hw/ddt_pkg.sv */
package ddt_pkg;

  localparam int  DDT_ADC_W      = 14;
  localparam int  DDT_PAD_W      = 2;
  localparam int  DDT_SAMPLE_W   = 16;
  localparam int  DDT_CELL_W     = 18;
  localparam int  DDT_FIFO_DEPTH = 8;

  // Clock and link timing
  localparam real DDT_CLK_SYS_NS   = 25.0;
  localparam real DDT_TX_PERIOD_NS = 4.00;
  localparam real DDT_FWD_PHASE_DEG = 90.0;
  localparam real DDT_MARGIN_NS    = 1.0;
  localparam real DDT_FWD_LAG_NS   = DDT_TX_PERIOD_NS * DDT_FWD_PHASE_DEG / 360.0;
  localparam real DDT_DEBOUNCE_MS  = 5.0;
  localparam int  DDT_DEBOUNCE_CYC = int'($ceil(DDT_DEBOUNCE_MS * 1.0e6 / DDT_CLK_SYS_NS));

  // Reset values and constant cell levels
  localparam logic DDT_FWD_RISE_LVL = 1'b1;
  localparam logic DDT_FWD_FALL_LVL = 1'b0;
  localparam logic DDT_DUMMY_LVL    = 1'b0;
  localparam logic [DDT_SAMPLE_W-1:0] DDT_SAMPLE_RST = 16'h0000;

  typedef struct packed {
    logic [DDT_ADC_W-1:0] chan_b;
    logic [DDT_ADC_W-1:0] chan_a;
  } ddt_pair_t;

  typedef struct packed {
    logic                    dummy;
    logic                    sync;
    logic [DDT_SAMPLE_W-1:0] sample;
  } ddt_cell_t;

  typedef enum {DDT_ST_HOLD, DDT_ST_RUN} ddt_state_t;

  function automatic logic [DDT_SAMPLE_W-1:0] ddt_pad(input logic [DDT_ADC_W-1:0] s);
    ddt_pad = {s, {DDT_PAD_W{1'b0}}};
  endfunction

endpackage

/* File: hw/ddt_tx.sv */
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module ddt_fifo #(
  parameter int W     = 28,
  parameter int DEPTH = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [W-1:0]  mem_d [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic          in_ready_q, in_ready_d, out_valid_q, out_valid_d;
  logic          push, pop;

  always_comb begin
    push = in_valid && in_ready_q;
    pop  = out_ready && out_valid_q;
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d = (wr_q == LAST) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == LAST) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
    // Flags from next count so both are honest flops
    in_ready_d  = (cnt_d != FULL);
    out_valid_d = (cnt_d != '0);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_q        <= '0;
      rd_q        <= '0;
      cnt_q       <= '0;
      in_ready_q  <= 1'b0;
      out_valid_q <= 1'b0;
    end else begin
      wr_q        <= wr_d;
      rd_q        <= rd_d;
      cnt_q       <= cnt_d;
      in_ready_q  <= in_ready_d;
      out_valid_q <= out_valid_d;
    end
    mem_q <= mem_d;
  end

  assign in_ready  = in_ready_q;
  assign out_valid = out_valid_q;
  assign out_data  = mem_q[rd_q];

  a_fifo_no_overflow: assert property (@(posedge clk_sys) disable iff (reset)
    cnt_q == FULL |-> !in_ready_q)
    else $error("fifo full yet ready");
  a_fifo_no_underflow: assert property (@(posedge clk_sys) disable iff (reset)
    cnt_q == '0 |-> !out_valid_q)
    else $error("fifo empty yet valid");
endmodule

////////////////////////////////////////////////////////////////////////////////
module ddt_tx
  import ddt_pkg::*;
#(
  parameter int DEBOUNCE_CYC = DDT_DEBOUNCE_CYC,
  parameter int FIFO_DEPTH   = DDT_FIFO_DEPTH
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       pll_locked,
  input  wire logic       sync_request_button,
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire ddt_pair_t  in_pair,
  output ddt_cell_t       cell_rise,
  output ddt_cell_t       cell_fall,
  output logic            fwd_clk_rise,
  output logic            fwd_clk_fall,
  output logic            sample_strobe
);
  localparam int DBW = $clog2(DEBOUNCE_CYC + 1);
  localparam logic [DBW-1:0] DB_LAST = DBW'(DEBOUNCE_CYC - 1);

  ddt_state_t     state_q, state_d;
  ddt_pair_t      fifo_data;
  logic           fifo_valid, fifo_ready;
  ddt_cell_t      rise_q, rise_d, fall_q, fall_d;
  logic           fwd_rise_q, fwd_rise_d, fwd_fall_q, fwd_fall_d;
  logic           strobe_q, strobe_d;
  logic           btn_q, btn_d, stable_q, stable_d, sync_q, sync_d;
  logic [DBW-1:0] db_cnt_q, db_cnt_d;

  ddt_fifo #(.W($bits(ddt_pair_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (in_pair),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Debounce: level must stay put for the full window before it counts
  always_comb begin
    btn_d    = sync_request_button;
    stable_d = stable_q;
    sync_d   = 1'b0;
    db_cnt_d = '0;
    if (btn_q != stable_q) begin
      db_cnt_d = db_cnt_q + 1'b1;
      if (db_cnt_q == DB_LAST) begin
        stable_d = btn_q;
        db_cnt_d = '0;
        sync_d   = btn_q;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      btn_q    <= 1'b0;
      stable_q <= 1'b0;
      sync_q   <= 1'b0;
      db_cnt_q <= '0;
    end else begin
      btn_q    <= btn_d;
      stable_q <= stable_d;
      sync_q   <= sync_d;
      db_cnt_q <= db_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Launch side. Cell words feed an external DDR output cell on the
  // zero-phase clock; the forwarded clock cell sits on the 90 degree clock.
  always_comb begin
    state_d    = state_q;
    case (state_q)
      DDT_ST_HOLD: if (pll_locked) state_d = DDT_ST_RUN;
      DDT_ST_RUN:  if (!pll_locked) state_d = DDT_ST_HOLD;
      default:     state_d = DDT_ST_HOLD;
    endcase
    fifo_ready = (state_q == DDT_ST_RUN);
    strobe_d   = fifo_ready && fifo_valid;
    rise_d     = '{dummy: DDT_DUMMY_LVL, sync: sync_q, sample: DDT_SAMPLE_RST};
    fall_d     = rise_d;
    if (strobe_d) begin
      rise_d.sample = ddt_pad(fifo_data.chan_a);
      fall_d.sample = ddt_pad(fifo_data.chan_b);
    end
    // Constant one/zero through a register cell; reset loads the same levels
    fwd_rise_d = DDT_FWD_RISE_LVL;
    fwd_fall_d = DDT_FWD_FALL_LVL;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q    <= DDT_ST_HOLD;
      rise_q     <= '{dummy: DDT_DUMMY_LVL, sync: 1'b0, sample: DDT_SAMPLE_RST};
      fall_q     <= '{dummy: DDT_DUMMY_LVL, sync: 1'b0, sample: DDT_SAMPLE_RST};
      fwd_rise_q <= DDT_FWD_RISE_LVL;
      fwd_fall_q <= DDT_FWD_FALL_LVL;
      strobe_q   <= 1'b0;
    end else begin
      state_q    <= state_d;
      rise_q     <= rise_d;
      fall_q     <= fall_d;
      fwd_rise_q <= fwd_rise_d;
      fwd_fall_q <= fwd_fall_d;
      strobe_q   <= strobe_d;
    end
  end

  assign cell_rise     = rise_q;
  assign cell_fall     = fall_q;
  assign fwd_clk_rise  = fwd_rise_q;
  assign fwd_clk_fall  = fwd_fall_q;
  assign sample_strobe = strobe_q;

  ////////////////////////////////////////////////////////////////////////////
  a_pad_low_zero: assert property (@(posedge clk_sys) disable iff (reset)
    cell_rise.sample[DDT_PAD_W-1:0] == '0 && cell_fall.sample[DDT_PAD_W-1:0] == '0)
    else $error("low pad bits not zero");
  a_chan_a_rise: assert property (@(posedge clk_sys) disable iff (reset)
    fifo_valid && fifo_ready |=> cell_rise.sample == ddt_pad($past(fifo_data.chan_a)))
    else $error("channel A not on rising half");
  a_chan_b_fall: assert property (@(posedge clk_sys) disable iff (reset)
    fifo_valid && fifo_ready |=> cell_fall.sample == ddt_pad($past(fifo_data.chan_b)))
    else $error("channel B not on falling half");
  a_dummy_zero: assert property (@(posedge clk_sys) disable iff (reset)
    !cell_rise.dummy && !cell_fall.dummy && cell_rise.sync == cell_fall.sync)
    else $error("dummy bit set or sync halves differ");
  a_fwd_levels: assert property (@(posedge clk_sys)
    ##1 fwd_clk_rise && !fwd_clk_fall)
    else $error("forwarded clock cell levels wrong");
  a_sync_single: assert property (@(posedge clk_sys) disable iff (reset)
    cell_rise.sync |=> !cell_rise.sync)
    else $error("sync longer than one word");
  a_sync_debounced: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(sync_q) |-> $past(btn_q, 2) && $past(btn_q, 1))
    else $error("sync without steady press");
  a_hold_unlocked: assert property (@(posedge clk_sys) disable iff (reset)
    !pll_locked |-> ##1 !fifo_ready ##1 cell_rise.sample == '0 && !sample_strobe)
    else $error("samples sent while unlocked");
  a_reset_clean: assert property (@(posedge clk_sys)
    reset |=> cell_rise.sample == '0 && !cell_rise.sync && !sample_strobe)
    else $error("output not clean after reset");
endmodule

/* File: dv/ddt_dac_model.sv */
`timescale 1ns/10ps
////////////////////////////////////////
module ddt_dac_model
  import ddt_pkg::*;
(
  input wire logic      clk_sys,
  input wire logic      reset,
  input wire ddt_cell_t cell_rise,
  input wire ddt_cell_t cell_fall,
  input wire logic      fwd_clk_rise,
  input wire logic      fwd_clk_fall,
  input wire logic      sample_strobe
);
  logic [31:0] got[$];
  int          syncs = 0;
  int          bad   = 0;
  // Latches A from the rising half, B from the falling half
  // Idle while in reset: before the first edge the outputs are still unknown
  always @(posedge clk_sys) begin
    if (!reset) begin
      if (sample_strobe === 1'b1) got.push_back({cell_rise.sample, cell_fall.sample});
      if (cell_rise.sync === 1'b1) syncs++;
      if (cell_rise.dummy !== 1'b0 || cell_fall.dummy !== 1'b0) bad++;
      if (fwd_clk_rise !== 1'b1 || fwd_clk_fall !== 1'b0) bad++;
    end
  end
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/10ps
////////////////////////////////////////
module testbench;
  import ddt_pkg::*;
  localparam int DB = 8;
  logic        clk_sys, reset, pll_locked, btn, in_valid;
  logic        in_ready, fwd_r, fwd_f, strobe;
  ddt_pair_t   in_pair;
  ddt_cell_t   c_r, c_f;
  int          failures = 0;
  int          checks   = 0;
  logic [31:0] exp_q[$];

  ddt_tx #(.DEBOUNCE_CYC(DB), .FIFO_DEPTH(DDT_FIFO_DEPTH)) u_dut (
    .clk_sys(clk_sys), .reset(reset), .pll_locked(pll_locked),
    .sync_request_button(btn), .in_valid(in_valid), .in_ready(in_ready),
    .in_pair(in_pair), .cell_rise(c_r), .cell_fall(c_f),
    .fwd_clk_rise(fwd_r), .fwd_clk_fall(fwd_f), .sample_strobe(strobe));
  ddt_dac_model u_dac (
    .clk_sys(clk_sys), .reset(reset), .cell_rise(c_r), .cell_fall(c_f),
    .fwd_clk_rise(fwd_r), .fwd_clk_fall(fwd_f), .sample_strobe(strobe));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #2;
    end
  endtask

  // Wide enough for the whole output word in one compare
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Leaves in_valid high so back-to-back pushes never toggle it twice
  task automatic push(input logic [13:0] a, input logic [13:0] b);
    int n;
    n = 0;
    in_valid = 1'b1;
    in_pair  = '{chan_b: b, chan_a: a};
    while (in_ready !== 1'b1 && n < 50) begin
      n++;
      tick(1);
    end
    tick(1);
    exp_q.push_back({a, 2'b00, b, 2'b00});
  endtask

  task automatic cmp_stream();
    tick(20);
    chk(u_dac.got.size(), exp_q.size());
    foreach (exp_q[i]) if (i < u_dac.got.size()) chk(u_dac.got[i], exp_q[i]);
    u_dac.got.delete();
    exp_q.delete();
  endtask

  ////////////////////////////////////////
  task automatic t_reset();
    reset = 1'b1;
    tick(2);
    chk({c_r, c_f, strobe, in_ready}, 38'h0);
    chk({fwd_r, fwd_f}, 2'b10);
    reset = 1'b0;
    tick(2);
    chk(in_ready, 1'b1);
  endtask

  task automatic t_stream();
    pll_locked = 1'b1;
    push(14'h3fff, 14'h0000);
    push(14'h2aaa, 14'h1555);
    push(14'h0001, 14'h2000);
    in_valid = 1'b0;
    cmp_stream();
  endtask

  // Lock held low stalls the output so the buffer fills and refuses
  task automatic t_fill();
    pll_locked = 1'b0;
    tick(2);
    for (int i = 0; i < 8; i++) push(14'(i * 3 + 1), 14'(14'h3ff0 - i));
    in_valid = 1'b0;
    tick(2);
    chk(in_ready, 1'b0);
    in_valid = 1'b1;
    in_pair  = '{chan_b: 14'h1111, chan_a: 14'h2222};
    tick(3);
    in_valid = 1'b0;
    chk(u_dac.got.size(), 0);
    pll_locked = 1'b1;
    cmp_stream();
  endtask

  task automatic t_sync();
    int s0;
    s0  = u_dac.syncs;
    btn = 1'b1;
    tick(DB / 2);
    btn = 1'b0;
    tick(DB + 6);
    chk(u_dac.syncs, s0);
    btn = 1'b1;
    tick(DB + 6);
    btn = 1'b0;
    tick(DB + 6);
    chk(u_dac.syncs, s0 + 1);
    chk(u_dac.bad, 0);
  endtask

  task automatic final_report();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #(25 * 5000);
    failures++;
    final_report();
  end

  initial begin
    reset      = 1'b1;
    pll_locked = 1'b0;
    btn        = 1'b0;
    in_valid   = 1'b0;
    in_pair    = '0;
    #2;
    t_reset();
    t_stream();
    t_fill();
    t_sync();
    final_report();
  end
endmodule
